/* hdl/deac_ctrl.sv */
// Overview of operation
// [R1] An eight-bit data register holds the byte to program or last byte read.
// [R2] Array depth is a parameter: 128 bytes (0h-7Fh) or 256 bytes (0h-FFh).
// [R3] Large variant decodes all eight address bits; top bit picks upper half.
// [R4] Small variant uses seven bits; top bit still decoded, software keeps it zero.
// [R5] Programming a byte erases the location first, no separate erase command.
// [R6] An internal timer sets program duration; hardware signals completion.
// [R7] Under code protection the CPU keeps access, the external programmer is denied.
// [R8] Control register has four low bits; upper four read zero.
// [R9] Read and program start bits are set-only; hardware clears them on completion.
// [R10] Programming needs the permit bit; permit bit is cleared at power-up.
// [R11] External pin or watchdog reset during programming sets the abort flag.
// [R12] Data and address registers keep their contents across such a reset.
// [R13] Program completion sets the done flag; only software clears it.
// [R14] Unlock register has no storage and reads zero.
// [R15] Unlock writes only qualify the program start sequence.
// [R16] Read start puts the addressed byte in the data register the next cycle.
// [R17] Software loads address and data, writes 55h then AAh, then sets start.
// [R18] Program start is ignored without permit and an immediately preceding unlock pair.
// [R19] Address and data are latched internally while programming is in progress.

`timescale 1ns/100ps
`default_nettype none
`include "deac_cfg.svh"

module deac_ctrl
  import deac_pkg::*;
#(
  parameter int DEPTH       = `DEAC_DEPTH_LARGE,
  parameter int PROG_CYCLES = `DEAC_PROG_CYCLES
)
(
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          por_i,
  input  wire logic          rst_ext_pin_i,
  input  wire logic          rst_watchdog_i,
  input  wire logic          code_protect_i,
  input  wire deac_sfr_req_s sfr_i,
  output logic      [7:0]    sfr_rdata_o,
  input  wire deac_ext_req_s ext_i,
  output logic      [7:0]    ext_rdata_o,
  output logic               ext_denied_o,
  output logic               program_done_irq_flag_o,
  output logic               program_busy_o
);

  logic [7:0]   nvm_data_reg;
  logic [7:0]   nvm_address_reg;
  logic         read_start_reg;
  logic         program_start_reg;
  logic         program_permit_bit_reg;
  logic         program_abort_flag_reg;
  logic         program_done_irq_flag_reg;
  deac_unlock_e unlock_reg;
  logic [7:0]   sfr_rdata_reg;
  logic [7:0]   ext_rdata_reg;
  logic         ext_denied_reg;

  logic          start_accept;
  logic          arr_busy;
  logic          arr_done;
  logic [7:0]    arr_rd_data;
  logic [7:0]    arr_ext_rdata;
  deac_ext_req_s ext_gated;
  logic          wr_irq;
  logic          wr_data;
  logic          wr_addr;
  logic          wr_ctrl;
  logic          wr_unlock;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // a write strobe aimed at one register address
  function automatic logic wr_hit(input deac_sfr_req_s req, input logic [`DEAC_ADDR_W-1:0] a);
    wr_hit = req.wr && (req.addr == a);
  endfunction : wr_hit

  // upper four control bits do not exist and read zero
  function automatic logic [7:0] ctl_view(input logic abort, input logic permit, input logic wr, input logic rd);
    ctl_view = {`DEAC_CTL_UPPER_ZERO, abort, permit, wr, rd}; // [R8]
  endfunction : ctl_view

  // only the done bit of the flag register lives in this block
  function automatic logic [7:0] irq_view(input logic done);
    irq_view                     = `DEAC_RST_BYTE;
    irq_view[`DEAC_IRQ_DONE_BIT] = done; // [R13]
  endfunction : irq_view

  ////////////////////////////////////////////////////////////////////////
  // write decode

  always_comb
  begin
    wr_irq    = wr_hit(sfr_i, `DEAC_ADDR_IRQ_FLAGS);
    wr_data   = wr_hit(sfr_i, `DEAC_ADDR_DATA);
    wr_addr   = wr_hit(sfr_i, `DEAC_ADDR_ADDRESS);
    wr_ctrl   = wr_hit(sfr_i, `DEAC_ADDR_CONTROL);
    wr_unlock = wr_hit(sfr_i, `DEAC_ADDR_UNLOCK);
  end

  // start accepted only with permit, armed unlock and no operation running
  always_comb
  begin
    start_accept = wr_ctrl && sfr_i.wdata[`DEAC_CTL_WR_BIT];
    start_accept = start_accept && program_permit_bit_reg; // [R10] [R18]
    start_accept = start_accept && (unlock_reg == UNL_ARMED); // [R18]
    start_accept = start_accept && !program_start_reg; // [R9]
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock sequence tracker

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      unlock_reg <= UNL_IDLE;
    else if (sfr_i.wr)
    begin
      // any other write in between breaks the sequence
      if (wr_unlock && sfr_i.wdata == `DEAC_UNLOCK_KEY1)
        unlock_reg <= UNL_GOT_FIRST; // [R15] [R17]
      else if (wr_unlock && sfr_i.wdata == `DEAC_UNLOCK_KEY2 && unlock_reg == UNL_GOT_FIRST)
        unlock_reg <= UNL_ARMED; // [R15] [R17]
      else
        unlock_reg <= UNL_IDLE; // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data register

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      // other resets keep the byte for a retry [R12]
      if (por_i)
        nvm_data_reg <= `DEAC_RST_BYTE;
    end
    else if (read_start_reg)
      nvm_data_reg <= arr_rd_data; // [R16]
    else if (wr_data)
      nvm_data_reg <= sfr_i.wdata; // [R1]
  end

  ////////////////////////////////////////////////////////////////////////
  // address register

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      // other resets keep the address for a retry [R12]
      if (por_i)
        nvm_address_reg <= `DEAC_RST_BYTE;
    end
    else if (wr_addr)
      nvm_address_reg <= sfr_i.wdata; // [R3] [R4]
  end

  ////////////////////////////////////////////////////////////////////////
  // read start bit

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      read_start_reg <= `DEAC_RST_FLAG;
    else if (read_start_reg)
      read_start_reg <= 1'b0; // [R9]
    else if (wr_ctrl && sfr_i.wdata[`DEAC_CTL_RD_BIT])
      read_start_reg <= 1'b1; // [R9] [R16]
  end

  ////////////////////////////////////////////////////////////////////////
  // program start bit

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      program_start_reg <= `DEAC_RST_FLAG;
    else if (start_accept)
      program_start_reg <= 1'b1; // [R9]
    else if (arr_done)
      program_start_reg <= 1'b0; // [R9]
  end

  ////////////////////////////////////////////////////////////////////////
  // permit bit

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      program_permit_bit_reg <= `DEAC_RST_FLAG; // [R10]
    else if (wr_ctrl)
      program_permit_bit_reg <= sfr_i.wdata[`DEAC_CTL_PERMIT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // abort flag

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      if (por_i)
        program_abort_flag_reg <= `DEAC_RST_FLAG;
      else if (arr_busy && (rst_ext_pin_i || rst_watchdog_i))
        program_abort_flag_reg <= 1'b1; // [R11]
    end
    else if (wr_ctrl)
      program_abort_flag_reg <= sfr_i.wdata[`DEAC_CTL_ABORT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // done flag, set wins over software clear

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      program_done_irq_flag_reg <= `DEAC_RST_FLAG;
    else if (arr_done)
      program_done_irq_flag_reg <= 1'b1; // [R13]
    else if (wr_irq)
      program_done_irq_flag_reg <= sfr_i.wdata[`DEAC_IRQ_DONE_BIT]; // [R13]
  end

  ////////////////////////////////////////////////////////////////////////
  // read back

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      sfr_rdata_reg <= `DEAC_RST_BYTE;
    else if (sfr_i.rd)
    begin
      case (sfr_i.addr)
        `DEAC_ADDR_IRQ_FLAGS:
          sfr_rdata_reg <= irq_view(program_done_irq_flag_reg); // [R13]
        `DEAC_ADDR_DATA:
          sfr_rdata_reg <= nvm_data_reg;
        `DEAC_ADDR_ADDRESS:
          sfr_rdata_reg <= nvm_address_reg;
        `DEAC_ADDR_CONTROL:
          sfr_rdata_reg <= ctl_view(program_abort_flag_reg, program_permit_bit_reg, // [R8]
                                    program_start_reg, read_start_reg);
        `DEAC_ADDR_UNLOCK:
          sfr_rdata_reg <= `DEAC_RST_BYTE; // [R14]
        default:
          sfr_rdata_reg <= `DEAC_RST_BYTE;
      endcase
    end
    else
      sfr_rdata_reg <= `DEAC_RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////
  // external programmer port

  always_comb
  begin
    ext_gated    = ext_i;
    ext_gated.we = ext_i.we && !code_protect_i; // [R7]
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ext_rdata_reg  <= `DEAC_RST_BYTE;
      ext_denied_reg <= `DEAC_RST_FLAG;
    end
    else
    begin
      ext_denied_reg <= code_protect_i; // [R7]
      ext_rdata_reg  <= code_protect_i ? `DEAC_RST_BYTE : arr_ext_rdata; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array with its own program timer

  deac_array #(
    .DEPTH       (DEPTH), // [R2]
    .PROG_CYCLES (PROG_CYCLES)
  ) u_array (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .start_i     (start_accept),
    .addr_i      (nvm_address_reg),
    .data_i      (nvm_data_reg),
    .rd_addr_i   (nvm_address_reg),
    .ext_i       (ext_gated),
    .rd_data_o   (arr_rd_data),
    .ext_rdata_o (arr_ext_rdata),
    .busy_o      (arr_busy),
    .done_o      (arr_done)
  );

  assign sfr_rdata_o             = sfr_rdata_reg;
  assign ext_rdata_o             = ext_rdata_reg;
  assign ext_denied_o            = ext_denied_reg;
  assign program_done_irq_flag_o = program_done_irq_flag_reg;
  assign program_busy_o          = program_start_reg;

endmodule : deac_ctrl

`default_nettype wire

/* hdl/deac_cfg.svh */
`ifndef DEAC_CFG_SVH
`define DEAC_CFG_SVH

// register file addresses
`define DEAC_ADDR_W           9
`define DEAC_ADDR_IRQ_FLAGS   9'h00C
`define DEAC_ADDR_DATA        9'h09A
`define DEAC_ADDR_ADDRESS     9'h09B
`define DEAC_ADDR_CONTROL     9'h09C
`define DEAC_ADDR_UNLOCK      9'h09D

// control register fields
`define DEAC_CTL_RD_BIT       0
`define DEAC_CTL_WR_BIT       1
`define DEAC_CTL_PERMIT_BIT   2
`define DEAC_CTL_ABORT_BIT    3
`define DEAC_CTL_UPPER_ZERO   4'h0

// flag register field
`define DEAC_IRQ_DONE_BIT     7

// reset values
`define DEAC_RST_BYTE         8'h00
`define DEAC_RST_FLAG         1'b0

// unlock keys
`define DEAC_UNLOCK_KEY1      8'h55
`define DEAC_UNLOCK_KEY2      8'hAA

// array sizes and erased byte value
`define DEAC_DEPTH_SMALL      128
`define DEAC_DEPTH_LARGE      256
`define DEAC_ERASED_BYTE      8'hFF

// timing
`define DEAC_CLK_PERIOD_NS    20
`define DEAC_PROG_TIME_NS     4000000
`define DEAC_PROG_CYCLES      ((`DEAC_PROG_TIME_NS + `DEAC_CLK_PERIOD_NS - 1) / `DEAC_CLK_PERIOD_NS)

`endif

/* hdl/deac_pkg.sv */
package deac_pkg;

  typedef struct packed {
    logic [8:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } deac_sfr_req_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } deac_ext_req_s;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_FIRST,
    UNL_ARMED
  } deac_unlock_e;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ERASE,
    PH_STORE
  } deac_phase_e;

endpackage : deac_pkg

/* hdl/deac_array.sv */
`timescale 1ns/100ps
`default_nettype none
`include "deac_cfg.svh"

module deac_array
  import deac_pkg::*;
#(
  parameter int DEPTH       = `DEAC_DEPTH_LARGE,
  parameter int PROG_CYCLES = `DEAC_PROG_CYCLES
)
(
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          start_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [7:0]    data_i,
  input  wire logic [7:0]    rd_addr_i,
  input  wire deac_ext_req_s ext_i,
  output logic      [7:0]    rd_data_o,
  output logic      [7:0]    ext_rdata_o,
  output logic               busy_o,
  output logic               done_o
);

  localparam int ERASE_CYCLES = (PROG_CYCLES / 2 < 1) ? 1 : PROG_CYCLES / 2;
  localparam int STORE_CYCLES = (PROG_CYCLES - ERASE_CYCLES < 1) ? 1 : PROG_CYCLES - ERASE_CYCLES;

  logic [7:0]  mem [DEPTH];
  deac_phase_e phase_reg;
  logic [31:0] timer_reg;
  logic [7:0]  lat_addr_reg;
  logic [7:0]  lat_data_reg;

  // all eight bits decoded; beyond the array means no location
  function automatic logic hit(input logic [7:0] a);
    hit = (32'(a) < DEPTH);
  endfunction : hit

  assign rd_data_o   = hit(rd_addr_i) ? mem[rd_addr_i] : `DEAC_RST_BYTE;
  assign ext_rdata_o = hit(ext_i.addr) ? mem[ext_i.addr] : `DEAC_RST_BYTE;
  assign busy_o      = (phase_reg != PH_IDLE);
  // done on the storing edge so the start bit falls after exactly the program time
  assign done_o      = (phase_reg == PH_STORE) && (timer_reg == '0); // [R6]

  ////////////////////////////////////////////////////////////////////////
  // address and data held for the whole operation

  always_ff @(posedge clk_i)
  begin
    if (start_i && phase_reg == PH_IDLE)
    begin
      lat_addr_reg <= addr_i; // [R19]
      lat_data_reg <= data_i; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self timed erase then store

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      phase_reg <= PH_IDLE;
      timer_reg <= '0;
    end
    else
    begin
      case (phase_reg)
        PH_IDLE:
        begin
          if (start_i)
          begin
            phase_reg <= PH_ERASE; // [R5]
            timer_reg <= 32'(ERASE_CYCLES - 1); // [R6]
          end
        end
        PH_ERASE:
        begin
          if (timer_reg == '0)
          begin
            phase_reg <= PH_STORE;
            timer_reg <= 32'(STORE_CYCLES - 1);
          end
          else
            timer_reg <= timer_reg - 32'd1;
        end
        PH_STORE:
        begin
          if (timer_reg == '0)
          begin
            phase_reg <= PH_IDLE; // [R6]
          end
          else
            timer_reg <= timer_reg - 32'd1;
        end
        default:
          phase_reg <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array storage

  always_ff @(posedge clk_i)
  begin
    if (nrst_i && phase_reg == PH_ERASE && timer_reg == '0 && hit(lat_addr_reg))
      mem[lat_addr_reg] <= `DEAC_ERASED_BYTE; // [R5]
    else if (nrst_i && phase_reg == PH_STORE && timer_reg == '0 && hit(lat_addr_reg))
      mem[lat_addr_reg] <= lat_data_reg;
    else if (ext_i.we && phase_reg == PH_IDLE && hit(ext_i.addr))
      mem[ext_i.addr] <= ext_i.wdata;
  end

endmodule : deac_array

`default_nettype wire

/* tb/deac_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "deac_cfg.svh"

module deac_ctrl_monitor
  import deac_pkg::*;
#(
  parameter int PROG_CYCLES = 8
)
(
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          code_protect_i,
  input  wire deac_sfr_req_s sfr_i,
  input  wire logic [7:0]    sfr_rdata_o,
  input  wire logic [7:0]    ext_rdata_o,
  input  wire logic          ext_denied_o,
  input  wire logic          program_done_irq_flag_o,
  input  wire logic          program_busy_o
);
  logic k1_q;
  logic k2_q;
  logic permit_q;
  logic go_q;
  int   cnt_q;
  wire logic unl_w = sfr_i.wr && sfr_i.addr == `DEAC_ADDR_UNLOCK;
  wire logic ctl_w = sfr_i.wr && sfr_i.addr == `DEAC_ADDR_CONTROL;

  // mirror of unlock pairing and permit
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      k1_q     <= 1'b0;
      k2_q     <= 1'b0;
      permit_q <= 1'b0;
    end
    else if (sfr_i.wr)
    begin
      k1_q <= unl_w && sfr_i.wdata == `DEAC_UNLOCK_KEY1;
      k2_q <= k1_q && unl_w && sfr_i.wdata == `DEAC_UNLOCK_KEY2;
      if (ctl_w)
        permit_q <= sfr_i.wdata[2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    go_q  <= nrst_i && ctl_w && sfr_i.wdata[1] && k2_q && permit_q && !program_busy_o;
    cnt_q <= (nrst_i && program_busy_o) ? cnt_q + 1 : 0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  upper_bits_a:
    assert property (sfr_i.rd && sfr_i.addr == `DEAC_ADDR_CONTROL |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("control upper bits not zero");
  unlock_zero_a:
    assert property (sfr_i.rd && sfr_i.addr == `DEAC_ADDR_UNLOCK |=> sfr_rdata_o == 8'h00)
    else $error("unlock read not zero");
  start_gated_a:
    assert property ($rose(program_busy_o) == go_q)
    else $error("program start not matching unlock sequence");
  busy_length_a:
    assert property ($fell(program_busy_o) && $past(nrst_i) |-> cnt_q == PROG_CYCLES)
    else $error("program length wrong");
  busy_held_a:
    assert property (program_busy_o && cnt_q < PROG_CYCLES - 1 |=> program_busy_o)
    else $error("program cut short");
  done_at_end_a:
    assert property ($fell(program_busy_o) && $past(nrst_i) |-> program_done_irq_flag_o)
    else $error("done flag missing at end");
  done_sticky_a:
    assert property (program_done_irq_flag_o && !(sfr_i.wr && sfr_i.addr == `DEAC_ADDR_IRQ_FLAGS)
      |=> program_done_irq_flag_o)
    else $error("done flag cleared by hardware");
  ext_blocked_a:
    assert property (code_protect_i |=> ext_rdata_o == 8'h00 && ext_denied_o)
    else $error("external access not denied");
endmodule : deac_ctrl_monitor

bind deac_ctrl deac_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .code_protect_i(code_protect_i), .sfr_i(sfr_i),
  .sfr_rdata_o(sfr_rdata_o), .ext_rdata_o(ext_rdata_o), .ext_denied_o(ext_denied_o),
  .program_done_irq_flag_o(program_done_irq_flag_o), .program_busy_o(program_busy_o));

`default_nettype wire

/* tb/test_deac_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "deac_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module test_deac_ctrl
  import deac_pkg::*;
;
  logic          clk_i;
  logic          nrst_i;
  logic          por_i;
  logic          pin_i;
  logic          wdt_i;
  logic          prot_i;
  deac_sfr_req_s sfr;
  deac_ext_req_s ext;
  logic [7:0]    rdata;
  logic [7:0]    erdata;
  logic          denied;
  logic          done;
  logic          busy;
  int            n_errors = 0;
  int            num_checks = 0;
  int            cyc = 0;
  logic [7:0]    ta [5] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h00};
  logic [7:0]    td [5] = '{8'hA5, 8'h3C, 8'hC3, 8'h96, 8'h5A};

  deac_ctrl #(.DEPTH(256), .PROG_CYCLES(8)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .por_i(por_i), .rst_ext_pin_i(pin_i), .rst_watchdog_i(wdt_i),
    .code_protect_i(prot_i), .sfr_i(sfr), .sfr_rdata_o(rdata), .ext_i(ext), .ext_rdata_o(erdata),
    .ext_denied_o(denied), .program_done_irq_flag_o(done), .program_busy_o(busy));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr <= '{a, 1'b1, 1'b0, d};
    @(posedge clk_i);
    sfr <= '0;
  endtask : wr

  task automatic rx(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_i);
    sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk_i);
    sfr <= '0;
    @(negedge clk_i);
    `CHK(rdata, e)
  endtask : rx

  // array read through the data register
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    wr(`DEAC_ADDR_ADDRESS, {1'b0, a});
    wr(`DEAC_ADDR_CONTROL, 8'h01);
    rx(`DEAC_ADDR_DATA, e);
  endtask : rdb

  task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k1, input logic [7:0] k2);
    wr(`DEAC_ADDR_DATA, d);
    wr(`DEAC_ADDR_ADDRESS, {1'b0, a});
    wr(`DEAC_ADDR_CONTROL, 8'h04);
    wr(`DEAC_ADDR_UNLOCK, k1);
    wr(`DEAC_ADDR_UNLOCK, k2);
    wr(`DEAC_ADDR_CONTROL, 8'h06);
    @(negedge clk_i);
  endtask : prog

  task automatic idle_wait;
    for (int n = 0; n < 40 && busy !== 1'b0; n++)
      @(negedge clk_i);
  endtask : idle_wait

  task automatic xop(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ext <= '{w, a, d};
    @(posedge clk_i);
    ext <= '0;
    @(negedge clk_i);
  endtask : xop

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst_i, por_i, pin_i, wdt_i, prot_i} = 5'b01000;
    sfr = '0;
    ext = '0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    por_i  <= 1'b0;
    rx(`DEAC_ADDR_CONTROL, 8'h00);
    rx(`DEAC_ADDR_IRQ_FLAGS, 8'h00);
    rx(9'h1FF, 8'h00);
    wr(`DEAC_ADDR_CONTROL, 8'hFF);
    rx(`DEAC_ADDR_CONTROL, 8'h0C);
    wr(`DEAC_ADDR_CONTROL, 8'h00);
    $display("test 1 done");
    // refused starts: no permit, wrong key, swapped keys
    wr(`DEAC_ADDR_DATA, 8'h5A);
    wr(`DEAC_ADDR_ADDRESS, 8'h10);
    wr(`DEAC_ADDR_UNLOCK, `DEAC_UNLOCK_KEY1);
    wr(`DEAC_ADDR_UNLOCK, `DEAC_UNLOCK_KEY2);
    wr(`DEAC_ADDR_CONTROL, 8'h02);
    @(negedge clk_i);
    `CHK(busy, 1'b0)
    wr(`DEAC_ADDR_CONTROL, 8'h04);
    wr(`DEAC_ADDR_UNLOCK, `DEAC_UNLOCK_KEY1);
    wr(`DEAC_ADDR_UNLOCK, 8'hAB);
    wr(`DEAC_ADDR_CONTROL, 8'h06);
    @(negedge clk_i);
    `CHK(busy, 1'b0)
    wr(`DEAC_ADDR_CONTROL, 8'h04);
    wr(`DEAC_ADDR_UNLOCK, 8'hAA);
    wr(`DEAC_ADDR_UNLOCK, 8'h55);
    wr(`DEAC_ADDR_CONTROL, 8'h06);
    rx(`DEAC_ADDR_UNLOCK, 8'h00);
    `CHK(busy, 1'b0)
    rx(`DEAC_ADDR_DATA, 8'h5A);
    rx(`DEAC_ADDR_ADDRESS, 8'h10);
    $display("test 2 done");
    for (int i = 0; i < 5; i++)
    begin
      prog(ta[i], td[i], `DEAC_UNLOCK_KEY1, `DEAC_UNLOCK_KEY2);
      `CHK(busy, 1'b1)
      wr(`DEAC_ADDR_CONTROL, 8'h04);
      wr(`DEAC_ADDR_DATA, ~td[i]);
      @(negedge clk_i);
      `CHK(busy, 1'b1)
      xop(1'b0, ta[i], 8'h00);
      `CHK(erdata, `DEAC_ERASED_BYTE)
      idle_wait();
      rx(`DEAC_ADDR_IRQ_FLAGS, 8'h80);
      wr(`DEAC_ADDR_IRQ_FLAGS, 8'h00);
      rx(`DEAC_ADDR_IRQ_FLAGS, 8'h00);
    end
    for (int i = 1; i < 5; i++)
      rdb(ta[i], td[i]);
    $display("test 3 done");
    for (int c = 0; c < 2; c++)
    begin
      prog(8'h20, 8'h77, `DEAC_UNLOCK_KEY1, `DEAC_UNLOCK_KEY2);
      @(posedge clk_i);
      {nrst_i, pin_i, wdt_i} <= {1'b0, c == 0, c == 1};
      repeat (2) @(posedge clk_i);
      {nrst_i, pin_i, wdt_i} <= 3'b100;
      rx(`DEAC_ADDR_CONTROL, 8'h08);
      rx(`DEAC_ADDR_DATA, 8'h77);
      rx(`DEAC_ADDR_ADDRESS, 8'h20);
      wr(`DEAC_ADDR_CONTROL, 8'h00);
    end
    $display("test 4 done");
    xop(1'b0, 8'h7F, 8'h00);
    `CHK(erdata, 8'h3C)
    prot_i <= 1'b1;
    xop(1'b1, 8'h7F, 8'h11);
    `CHK(denied, 1'b1)
    `CHK(erdata, 8'h00)
    rdb(8'h7F, 8'h3C);
    prot_i <= 1'b0;
    $display("test 5 done");
    conclude();
  end
endmodule : test_deac_ctrl

`default_nettype wire
